/* rtl/otp_prog_pkg.sv */
// constants, types and timing for the otp byte programmer
// How it works
// (R1) each byte is programmed by a low program strobe of nominal 100 us
// (R2) every strobe pulse lasts between 95 and 105 us
// (R3) programming starts with the address at the first location
// (R4) first pass gives every address exactly one pulse, no verify
// (R5) then verify each address again from the first, reprogram only on mismatch
// (R6) on mismatch apply up to 10 more pulses, verifying after each
// (R7) still mismatching after 10 retries stops and flags failure
// (R8) a verified byte advances the address until all are checked
// (R9) with read supplies back, read all bytes and compare to source
// (R10) wait 150 ns after output enable low, allow 130 ns float
// (R11) id mode returns maker byte with select low, device byte high
// (R12) id mode holds address low except high-voltage line and select
// (R13) strobe with chip select low and oe high; verify with oe low
// (R14) report one pass or fail result and the failing address
package otp_prog_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] LAST_ADDR = 18'h3ffff;
  localparam int CLK_PERIOD_NS = 40;
  localparam int PULSE_NS = 100000;     // nominal strobe width
  localparam int PULSE_MIN_NS = 95000;
  localparam int PULSE_MAX_NS = 105000;
  localparam int OE_ACCESS_NS = 150;    // data valid from oe
  localparam int FLOAT_NS = 130;        // oe high to output float
  localparam int SETUP_NS = 2000;       // address/data/oe setup
  localparam int HOLD_NS = 2000;        // data hold after strobe
  localparam int PULSE_CYC = PULSE_NS / CLK_PERIOD_NS;
  localparam int OE_CYC = (OE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_CYC = (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_MIN_CYC =
    (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_MAX_CYC = PULSE_MAX_NS / CLK_PERIOD_NS;
  localparam int TMR_W = 12;
  localparam logic [3:0] RETRY_MAX = 4'ha;
  localparam logic [ADDR_W-1:0] ID_ADDR_MASK = 18'h00001;

  typedef enum logic [1:0] {
    OP_NONE, OP_PROGRAM, OP_IDENT
  } cmd_t;

  // pins toward the memory
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              chip_sel_n;
    logic              out_en_n;
    logic              program_strobe_n;
    logic              id_mode_high_voltage_line;
    logic              programming_supply;
    logic [DATA_W-1:0] data_out;
    logic              data_oe_n;
  } mem_pins_t;

  // result toward the host
  typedef struct packed {
    logic              done;
    logic              pass;
    logic [ADDR_W-1:0] fail_addr;
    logic [DATA_W-1:0] id_maker;
    logic [DATA_W-1:0] id_device;
  } result_t;
endpackage : otp_prog_pkg

/* rtl/otp_src_mem.sv */
// source image memory, one byte per memory location, registered read
`timescale 1ns/1ps
module otp_src_mem
  import otp_prog_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_wr,
  input  wire logic [ADDR_W-1:0] i_waddr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic [ADDR_W-1:0] i_raddr,
  output logic      [DATA_W-1:0] o_rdata
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // write port loaded by the host before a run
  always_ff @(posedge i_mclk) begin
    if (i_wr) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // read data comes out of a register, one cycle late
  always_ff @(posedge i_mclk) begin
    o_rdata <= mem[i_raddr];
  end
endmodule : otp_src_mem

/* rtl/otp_programmer.sv */
// host side programmer: program pass, verify/retry loop, final readback
`timescale 1ns/1ps
module otp_programmer
  import otp_prog_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_rst,
  input  wire cmd_t              i_cmd,
  input  wire logic              i_img_wr,
  input  wire logic [ADDR_W-1:0] i_img_addr,
  input  wire logic [DATA_W-1:0] i_img_data,
  input  wire logic [DATA_W-1:0] i_mem_data,
  output mem_pins_t              o_pins,
  output logic                   o_busy,
  output result_t                o_result
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD, ST_OE_WAIT, ST_SAMPLE,
    ST_FLOAT, ST_NEXT, ST_DONE
  } state_t;
  typedef enum logic [1:0] {
    PH_FIRST, PH_VERIFY, PH_READ, PH_ID
  } phase_t;

  state_t            state_ff;
  phase_t            phase_ff;
  logic [TMR_W-1:0]  tmr_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [3:0]        retry_ff;
  logic              mismatch_ff;
  logic [DATA_W-1:0] src_byte;
  logic              tmr_zero;
  mem_pins_t         pins_ff;
  result_t           res_ff;
  logic              busy_ff;
  logic              last_addr;

  assign tmr_zero = (tmr_ff == '0);
  assign last_addr = (phase_ff == PH_ID) ? addr_ff[0]
                                         : (addr_ff == LAST_ADDR);

  otp_src_mem u_src (
    .i_mclk  (i_mclk),
    .i_wr    (i_img_wr && !busy_ff),
    .i_waddr (i_img_addr),
    .i_wdata (i_img_data),
    .i_raddr (addr_ff),
    .o_rdata (src_byte)
  );

  // sequencer: setup, pulse, hold, oe wait and float wait their timer out before moving on
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_ff    <= ST_IDLE;
      phase_ff    <= PH_FIRST;
      tmr_ff      <= '0;
      addr_ff     <= '0;
      retry_ff    <= '0;
      mismatch_ff <= 1'b0;
    end else begin
      if (!tmr_zero) begin
        tmr_ff <= tmr_ff - 1'b1;
      end
      case (state_ff)
        ST_IDLE: begin
          addr_ff  <= '0;                                  // R3
          retry_ff <= '0;
          mismatch_ff <= 1'b0;  // no stale compare from a failed run
          if (i_cmd == OP_PROGRAM) begin
            phase_ff <= PH_FIRST;
            state_ff <= ST_SETUP;
            tmr_ff   <= TMR_W'(SETUP_CYC);
          end else if (i_cmd == OP_IDENT) begin
            phase_ff <= PH_ID;
            state_ff <= ST_SETUP;
            tmr_ff   <= TMR_W'(SETUP_CYC);
          end
        end
        ST_SETUP: begin
          // readback, ident and a verify read with no mismatch skip the strobe and go straight to oe
          if (tmr_zero) begin
            if (phase_ff == PH_READ || phase_ff == PH_ID ||
                (phase_ff == PH_VERIFY && !mismatch_ff)) begin
              state_ff <= ST_OE_WAIT;
              tmr_ff   <= TMR_W'(OE_CYC);
            end else begin
              state_ff <= ST_PULSE;
              tmr_ff   <= TMR_W'(PULSE_CYC - 1);           // R1 R2
            end
          end
        end
        ST_PULSE: begin
          if (tmr_zero) begin
            state_ff <= ST_HOLD;
            tmr_ff   <= TMR_W'(HOLD_CYC);
          end
        end
        ST_HOLD: begin
          if (tmr_zero) begin
            if (phase_ff == PH_FIRST) begin
              state_ff <= ST_NEXT;                         // R4
            end else begin
              state_ff <= ST_OE_WAIT;                      // R6
              tmr_ff   <= TMR_W'(OE_CYC);
            end
          end
        end
        ST_OE_WAIT: begin
          if (tmr_zero) begin
            state_ff <= ST_SAMPLE;                         // R10
          end
        end
        ST_SAMPLE: begin
          state_ff <= ST_FLOAT;
          tmr_ff   <= TMR_W'(FLOAT_CYC);                   // R10
          mismatch_ff <= (i_mem_data != src_byte);
        end
        ST_FLOAT: begin
          if (tmr_zero) begin
            if (phase_ff == PH_VERIFY && mismatch_ff) begin
              if (retry_ff == RETRY_MAX) begin
                state_ff <= ST_DONE;                       // R7
              end else begin
                retry_ff <= retry_ff + 1'b1;               // R6
                state_ff <= ST_SETUP;
                tmr_ff   <= TMR_W'(SETUP_CYC);
              end
            end else if (phase_ff == PH_READ && mismatch_ff) begin
              state_ff <= ST_DONE;                         // R9
            end else begin
              state_ff <= ST_NEXT;                         // R8
            end
          end
        end
        ST_NEXT: begin
          retry_ff    <= '0;
          mismatch_ff <= 1'b0;
          if (last_addr) begin
            addr_ff <= '0;                                 // R5
            if (phase_ff == PH_FIRST) begin
              phase_ff <= PH_VERIFY;
              state_ff <= ST_SETUP;
              tmr_ff   <= TMR_W'(SETUP_CYC);
            end else if (phase_ff == PH_VERIFY) begin
              phase_ff <= PH_READ;                         // R9
              state_ff <= ST_SETUP;
              tmr_ff   <= TMR_W'(SETUP_CYC);
            end else begin
              state_ff <= ST_DONE;
            end
          end else begin
            addr_ff  <= addr_ff + 1'b1;                    // R8
            state_ff <= ST_SETUP;
            tmr_ff   <= TMR_W'(SETUP_CYC);
          end
        end
        ST_DONE: begin
          if (i_cmd == OP_NONE) begin
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // pin drive; the first cycle of verify still has the source byte
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pins_ff <= '{addr: '0, chip_sel_n: 1'b1, out_en_n: 1'b1,
                   program_strobe_n: 1'b1, id_mode_high_voltage_line: 1'b0,
                   programming_supply: 1'b0, data_out: '0,
                   data_oe_n: 1'b1};
    end else begin
      pins_ff.addr <= (phase_ff == PH_ID) ? (addr_ff & ID_ADDR_MASK)
                                          : addr_ff;            // R12
      pins_ff.id_mode_high_voltage_line <=
        (state_ff != ST_IDLE && state_ff != ST_DONE &&
         phase_ff == PH_ID);                                    // R12
      // program supply only during the first pass and verify loop
      pins_ff.programming_supply <=
        (state_ff != ST_IDLE && state_ff != ST_DONE &&
         (phase_ff == PH_FIRST || phase_ff == PH_VERIFY));      // R9
      pins_ff.chip_sel_n <= (state_ff == ST_IDLE ||
                             state_ff == ST_DONE);              // R13
      pins_ff.program_strobe_n <= !(state_ff == ST_SETUP && tmr_zero &&
        (phase_ff == PH_FIRST ||
         (phase_ff == PH_VERIFY && mismatch_ff))) &&
        !(state_ff == ST_PULSE && !tmr_zero);                   // R1 R13
      pins_ff.out_en_n <= !(state_ff == ST_OE_WAIT ||
                            state_ff == ST_SAMPLE);             // R13
      pins_ff.data_out <= src_byte;
      // release data no later than oe falls; never driven during readback and ident
      pins_ff.data_oe_n <= !(state_ff == ST_SETUP || state_ff == ST_PULSE
                             || state_ff == ST_HOLD) ||
                           phase_ff == PH_READ || phase_ff == PH_ID;
    end
  end

  // result and identification capture
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      res_ff  <= '0;
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= (state_ff != ST_IDLE && state_ff != ST_DONE);
      if (state_ff == ST_IDLE && i_cmd != OP_NONE) begin
        res_ff.done <= 1'b0;
        res_ff.pass <= 1'b0;
      end
      if (state_ff == ST_SAMPLE && phase_ff == PH_ID) begin
        if (addr_ff[0]) begin
          res_ff.id_device <= i_mem_data;                  // R11
        end else begin
          res_ff.id_maker <= i_mem_data;                   // R11
        end
      end
      if (state_ff == ST_FLOAT && tmr_zero && mismatch_ff &&
          ((phase_ff == PH_VERIFY && retry_ff == RETRY_MAX) ||
           phase_ff == PH_READ)) begin
        res_ff.done      <= 1'b1;                          // R14
        res_ff.pass      <= 1'b0;
        res_ff.fail_addr <= addr_ff;
      end else if (state_ff == ST_NEXT && last_addr &&
                   (phase_ff == PH_READ || phase_ff == PH_ID)) begin
        res_ff.done <= 1'b1;                               // R14
        res_ff.pass <= 1'b1;
      end
    end
  end

  assign o_pins   = pins_ff;
  assign o_busy   = busy_ff;
  assign o_result = res_ff;

  // low strobe width counted in cycles
  logic [TMR_W-1:0] pw_ff;
  always_ff @(posedge i_mclk) begin
    if (i_rst || pins_ff.program_strobe_n) begin
      pw_ff <= '0;
    end else begin
      pw_ff <= pw_ff + 1'b1;
    end
  end

  // strobe width limits, counted in clock cycles
  pulse_max_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R2
    !pins_ff.program_strobe_n |-> pw_ff < TMR_W'(PULSE_MAX_CYC))
    else $error("program strobe held too long");
  pulse_min_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R2
    $rose(pins_ff.program_strobe_n) |->
      $past(pw_ff) >= TMR_W'(PULSE_MIN_CYC - 1))
    else $error("program strobe too short");

  // pin relations while strobing and reading
  strobe_oe_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R13
    !pins_ff.program_strobe_n |->
      pins_ff.out_en_n && !pins_ff.chip_sel_n)
    else $error("strobe with oe low or chip deselected");
  oe_strobe_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R13
    !pins_ff.out_en_n |-> pins_ff.program_strobe_n
      && pins_ff.data_oe_n)
    else $error("oe low while strobing or driving data");
  oe_select_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R13
    !pins_ff.out_en_n |-> !pins_ff.chip_sel_n)
    else $error("oe low with chip deselected");
  strobe_addr_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R1
    !pins_ff.program_strobe_n |-> $stable(pins_ff.addr) &&
      !pins_ff.data_oe_n && pins_ff.programming_supply)
    else $error("address, data or supply not held during strobe");
  hold_data_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R13
    $rose(pins_ff.program_strobe_n) |->
      !pins_ff.data_oe_n && $stable(pins_ff.addr))
    else $error("data or address released at strobe end");
  id_addr_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R12
    pins_ff.id_mode_high_voltage_line |->
      pins_ff.addr[ADDR_W-1:1] == '0 && pins_ff.program_strobe_n)
    else $error("id mode with upper address lines high");

  // read timing around output enable
  sample_wait_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R10
    state_ff == ST_SAMPLE |->
      $past(!pins_ff.out_en_n, 4))
    else $error("data sampled before access time");
  float_gap_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R10
    $rose(pins_ff.out_en_n) |-> pins_ff.data_oe_n [*4])
    else $error("data driven before outputs float");

  // sequence and completion toward the host
  start_addr_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R3
    state_ff == ST_IDLE && i_cmd == OP_PROGRAM |=> addr_ff == '0)
    else $error("programming did not start at first location");
  retry_cap_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R6
    retry_ff <= RETRY_MAX)
    else $error("retry count beyond limit");
  fail_stop_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R7
    state_ff == ST_FLOAT && tmr_zero && phase_ff == PH_VERIFY &&
    mismatch_ff && retry_ff == RETRY_MAX |=>
      state_ff == ST_DONE ##1 o_result.done && !o_result.pass)
    else $error("retry limit did not stop with fail");
  first_pass_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R4
    phase_ff == PH_FIRST |-> pins_ff.out_en_n)
    else $error("verify read during first pass");
  busy_done_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R14
    $rose(o_result.done) |=> !o_busy && o_result.done)
    else $error("busy still high after result");
endmodule : otp_programmer

/* testbench/otp_mem_model.sv */
// behavioural one-time programmable memory driven through its pins
`timescale 1ns/1ps
module otp_mem_model
  import otp_prog_pkg::*;
#(
  parameter logic [DATA_W-1:0] MAKER_CODE  = 8'h5a,  // arbitrary value
  parameter logic [DATA_W-1:0] DEVICE_CODE = 8'hc3   // arbitrary value
)(
  input  wire mem_pins_t         i_pins,
  output logic      [DATA_W-1:0] o_bus,
  output logic      [31:0]       o_viol,
  output logic      [31:0]       o_pulses,
  output logic      [31:0]       o_reads
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] dout;
  logic [DATA_W-1:0] last;
  logic              valid;
  realtime           t_fall;
  int                tok;

  // erased array reads all ones
  initial begin
    for (int a = 0; a < (1<<ADDR_W); a++) begin
      mem[a] = 8'hff;
    end
    o_viol = 0;
    o_pulses = 0;
    o_reads = 0;
    last = 8'h00;
    valid = 1'b0;
    tok = 0;
    t_fall = 0;
  end

  // strobe may only fall with chip select low and output enable high
  always @(negedge i_pins.program_strobe_n) begin
    t_fall = $realtime;
    if (i_pins.chip_sel_n || !i_pins.out_en_n) begin
      o_viol = o_viol + 1;
    end
  end

  // pulse end: width check, then bits only ever clear
  always @(posedge i_pins.program_strobe_n) begin
    if (t_fall > 0 && !i_pins.chip_sel_n) begin
      o_pulses = o_pulses + 1;
      if ($realtime - t_fall < PULSE_MIN_NS ||
          $realtime - t_fall > PULSE_MAX_NS) begin
        o_viol = o_viol + 1;
      end
      if (i_pins.programming_supply && !i_pins.data_oe_n) begin
        mem[i_pins.addr] = mem[i_pins.addr] & i_pins.data_out;
      end
    end
  end

  // output enable: data valid only after the access time
  always @(negedge i_pins.out_en_n) begin : oe_fall
    int my;
    tok = tok + 1;
    my = tok;
    valid = 1'b0;
    if (i_pins.id_mode_high_voltage_line && i_pins.addr[ADDR_W-1:1] != 0) begin
      o_viol = o_viol + 1;
    end
    if (i_pins.programming_supply) begin
      o_reads = o_reads + 1;
    end
    #(OE_ACCESS_NS);
    if (tok == my && !i_pins.out_en_n) begin
      valid = 1'b1;
    end
  end

  // release: a floating bus must not keep the last byte
  always @(posedge i_pins.out_en_n) begin
    tok = tok + 1;
    valid = 1'b0;
    if (!$isunknown(dout)) begin
      last = dout;
    end
  end

  // identification codes replace array data when the id line is high
  always @* begin
    dout = i_pins.id_mode_high_voltage_line ?
           (i_pins.addr[0] ? DEVICE_CODE : MAKER_CODE) :
           mem[i_pins.addr];
  end

  // wire level seen by the host
  always @* begin
    if (!i_pins.data_oe_n) begin
      o_bus = i_pins.data_out;
    end else if (!i_pins.chip_sel_n && !i_pins.out_en_n && valid) begin
      o_bus = dout;
    end else begin
      o_bus = ~last;
    end
  end
endmodule : otp_mem_model

/* testbench/tb_otp_programmer.sv */
// testbench: identification runs and the first NB strobes of the first program pass of the programmer
`timescale 1ns/1ps
module tb_otp_programmer;
  import otp_prog_pkg::*;
  localparam int NB = 9;
  localparam logic [DATA_W-1:0] MAKER = 8'h5a;  // arbitrary value
  localparam logic [DATA_W-1:0] DEV   = 8'hc3;  // arbitrary value
  logic              i_mclk;
  logic              i_rst;
  logic              i_img_wr;
  cmd_t              i_cmd;
  logic [ADDR_W-1:0] i_img_addr;
  logic [DATA_W-1:0] i_img_data;
  logic [DATA_W-1:0] bus;
  mem_pins_t         pins;
  logic              busy;
  result_t           res;
  logic [31:0]       viol;
  logic [31:0]       pulses;
  logic [31:0]       reads;
  logic [DATA_W-1:0] img [0:NB-1];
  logic              prev_n;
  int                fails;
  int                comparisons;
  int                seed;
  int                falls;
  int                n;

  otp_programmer i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_cmd(i_cmd),
    .i_img_wr(i_img_wr), .i_img_addr(i_img_addr), .i_img_data(i_img_data),
    .i_mem_data(bus), .o_pins(pins), .o_busy(busy), .o_result(res));
  otp_mem_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEV)) i_mem (
    .i_pins(pins), .o_bus(bus), .o_viol(viol), .o_pulses(pulses),
    .o_reads(reads));

  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end

  function automatic logic [DATA_W-1:0] exp_id(input logic sel);
    return sel ? DEV : MAKER;
  endfunction : exp_id

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_word(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic results();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  // ident run; the held command is dropped once the run is taken
  task automatic run_ident();
    @(negedge i_mclk) i_cmd = OP_IDENT;
    for (n = 0; busy !== 1'b1 && n < 100; n++) @(negedge i_mclk);
    i_cmd = OP_NONE;
    for (n = 0; res.done !== 1'b1 && n < 5000; n++) @(negedge i_mclk);
    chk_byte(res.id_maker, exp_id(1'b0));
    chk_byte(res.id_device, exp_id(1'b1));
    chk_word({res.done, res.pass}, 2'b11);
    repeat (10) @(negedge i_mclk);
    chk_word({res.done, busy}, 2'b10);
    $display("test ident finished");
  endtask : run_ident

  // every strobe fall: next address in order, image byte driven;
  // pins are looked at on the falling edge, where they have settled
  always @(negedge i_mclk) begin
    prev_n <= pins.program_strobe_n;
    if (prev_n === 1'b1 && pins.program_strobe_n === 1'b0) begin
      chk_word(pins.addr, 64'(falls));
      if (falls < NB) chk_byte(pins.data_out, img[falls]);
      chk_word({pins.data_oe_n, pins.programming_supply}, 2'b01);
      falls <= falls + 1;
    end
  end

  // watchdog sized well above the expected run length
  initial begin
    repeat (45000) @(posedge i_mclk);
    fails++;
    $display("watchdog expired");
    results();
  end

  initial begin
    seed = 34951;
    i_rst = 1'b1;
    i_cmd = OP_NONE;
    i_img_wr = 1'b0;
    i_img_addr = 18'h00000;
    i_img_data = 8'h00;
    falls = 0;
    prev_n = 1'b1;
    repeat (20) @(negedge i_mclk);
    i_rst = 1'b0;
    run_ident();
    // image with all-zero and all-one first two bytes, rest random
    for (int i = 0; i < NB; i++) begin
      img[i] = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
      @(negedge i_mclk);
      i_img_wr = 1'b1;
      i_img_addr = 18'(i);
      i_img_data = img[i];
    end
    @(negedge i_mclk) i_img_wr = 1'b0;
    @(negedge i_mclk) i_cmd = OP_PROGRAM;
    for (n = 0; busy !== 1'b1 && n < 100; n++) @(negedge i_mclk);
    // while busy, a new command and an image write must be refused
    i_cmd = OP_IDENT;
    chk_word(res.done, 1'b0);
    i_img_wr = 1'b1;
    i_img_addr = 18'(NB - 1);
    i_img_data = ~img[NB-1];
    @(negedge i_mclk) i_img_wr = 1'b0;
    for (n = 0; pulses < NB && n < NB * 2700; n++) @(negedge i_mclk);
    chk_word(falls, NB);
    chk_word(reads, 0);
    chk_word({busy, pins.id_mode_high_voltage_line}, 2'b10);
    $display("test first pass finished");
    // reset between pulses, mid-run
    i_rst = 1'b1;
    i_cmd = OP_NONE;
    repeat (2) @(negedge i_mclk);
    chk_word({pins.chip_sel_n, pins.out_en_n, pins.program_strobe_n,
              pins.data_oe_n, pins.programming_supply, busy}, 6'b111100);
    chk_word(pins.addr, 0);
    chk_word(64'(res), 0);
    i_rst = 1'b0;
    $display("test reset finished");
    run_ident();
    chk_word(viol, 0);
    results();
  end
endmodule : tb_otp_programmer
